/* File: lcdm_defs.svh */
`ifndef LCDM_DEFS_SVH
`define LCDM_DEFS_SVH

// ==========================================
// geometry
`define LCDM_COLS 102
`define LCDM_ROWS 9
`define LCDM_LAST_COL 7'h65
`define LCDM_LAST_ROW 4'h8
`define LCDM_COL_W 7
`define LCDM_ROW_W 4

// ==========================================
// register byte offsets
`define LCDM_OFF_MODE 8'h00
`define LCDM_OFF_PTR 8'h04
`define LCDM_OFF_CTRL 8'h08
`define LCDM_OFF_DATA 8'h0c
`define LCDM_OFF_STAT 8'h10

// ==========================================
// field positions
`define LCDM_MODE_LSB 0
`define LCDM_MODE_MSB 2
`define LCDM_DEVA_LSB 4
`define LCDM_DEVA_MSB 5
`define LCDM_PCOL_LSB 0
`define LCDM_PCOL_MSB 6
`define LCDM_PROW_LSB 8
`define LCDM_PROW_MSB 11
`define LCDM_RS_LSB 5
`define LCDM_RS_MSB 6
`define LCDM_STOP_BIT 12
`define LCDM_HWA_LSB 13
`define LCDM_HWA_MSB 14
`define LCDM_PHS_LSB 16
`define LCDM_PHS_MSB 19

// ==========================================
// register select values and resets
`define LCDM_RS_RAM 2'h1
`define LCDM_DEVA_RST 2'h0
`define LCDM_RS_RST 2'h0

`endif

/* File: lcdm_pkg.sv */
package lcdm_pkg;

	typedef enum logic [2:0] {
		LCDM_STATIC = 3'b000,
		LCDM_MUX2 = 3'b001,
		LCDM_MUX4 = 3'b010,
		LCDM_MUX6 = 3'b011,
		LCDM_MUX8 = 3'b100,
		LCDM_MUX9 = 3'b101
	} lcdm_mode_e;

endpackage

/* File: lcdm_scan.sv */
`timescale 1ns/1ps
`default_nettype none
`include "lcdm_defs.svh"

module lcdm_scan
	import lcdm_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire lcdm_mode_e mode,
	input wire logic step,
	output logic [3:0] phase,
	output logic [8:0] backplane_pin
);

	// ==========================================
	// phase sequencer
	logic [3:0] last_phase;
	logic [3:0] next_phase;

	function automatic logic [3:0] phase_of_pin(input lcdm_mode_e m, input int n);
		logic [3:0] p;
		p = 4'h0;
		case (m)
			LCDM_STATIC: p = 4'h0;
			LCDM_MUX2: p = 4'(n % 2);
			LCDM_MUX4: p = (n <= 4) ? 4'(n % 4) : 4'(8 - n);
			LCDM_MUX6: p = (n <= 5) ? 4'(n) : 4'(8 - n);
			LCDM_MUX8: p = (n == 8) ? 4'h0 : 4'(n);
			LCDM_MUX9: p = 4'(n);
			default: p = 4'h0;
		endcase
		return p;
	endfunction

	always_comb begin
		case (mode)
			LCDM_STATIC: last_phase = 4'h0;
			LCDM_MUX2: last_phase = 4'h1;
			LCDM_MUX4: last_phase = 4'h3;
			LCDM_MUX6: last_phase = 4'h5;
			LCDM_MUX8: last_phase = 4'h7;
			LCDM_MUX9: last_phase = 4'h8;
			default: last_phase = 4'h0;
		endcase
	end

	// a mode change mid-frame can leave phase past the end, so wrap on >=
	assign next_phase = !step ? ((phase > last_phase) ? 4'h0 : phase) :
		((phase >= last_phase) ? 4'h0 : phase + 4'h1);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase <= 4'h0;
		end else begin
			phase <= next_phase;
		end
	end

	// ==========================================
	// backplane pin mapping
	genvar gi;
	generate
		for (gi = 0; gi < `LCDM_ROWS; gi++) begin : g_bp
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					backplane_pin[gi] <= 1'b0;
				end else begin
					backplane_pin[gi] <= (phase_of_pin(mode, gi) == next_phase); // R1 R2 R3
				end
			end
		end
	endgenerate

	// ==========================================
	// checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// the first edge after release still shows the reset zeros
	chk_static_all_same: assert property ( // R1
		mode == LCDM_STATIC && $past(mode) == LCDM_STATIC && $past(presetn)
		|-> (&backplane_pin))
		else $error("static backplanes differ");
	chk_mux2_even_odd: assert property ( // R1
		mode == LCDM_MUX2 && $past(mode) == LCDM_MUX2 |->
		backplane_pin[0] == backplane_pin[2] && backplane_pin[1] == backplane_pin[7]
		&& backplane_pin[0] != backplane_pin[1])
		else $error("1:2 backplane pairing wrong");
	chk_mux4_mirror: assert property ( // R2
		mode == LCDM_MUX4 && $past(mode) == LCDM_MUX4 |->
		backplane_pin[1] == backplane_pin[7] && backplane_pin[3] == backplane_pin[5]
		&& backplane_pin[0] == backplane_pin[8] && backplane_pin[0] == backplane_pin[4])
		else $error("1:4 backplane mirror wrong");
	chk_mux9_onehot: assert property ( // R3
		mode == LCDM_MUX9 && $past(mode) == LCDM_MUX9 |-> $onehot(backplane_pin))
		else $error("1:9 backplanes not one-hot");

endmodule // lcdm_scan

`default_nettype wire

/* File: lcdm_top.sv */
// Contract
// R1 - static all pins phase 0; 1:2 alternates
// R2 - 1:4 and 1:6 mirrored phase tables
// R3 - 1:8 pins 0-7, pin 8 phase 0; 1:9 direct
// R4 - nine backplanes, 102 segments, column n drives n
// R5 - ram 102x9, one means element on
// R6 - ram row n scanned with backplane n
// R7 - segments from held display register
// R8 - display bytes stored on arrival
// R9 - host loads pointer before data
// R10 - pointer step per mode
// R11 - pointer stops at end, surplus discarded
// R12 - host reloads pointer after end
// R13 - host rewrites pointer after aborted transfer
// R14 - store only on address match, still advance
// R15 - host selects chip then sets pointer
// R16 - static: eight columns of row, msb first
// R17 - 1:2: four columns, odd bits row 0
// R18 - 1:4: two columns of four rows
// R19 - 1:6: six rows, bits wrap to next column
// R20 - 1:8: one column, bit 7 row 0
// R21 - 1:9: first pass rows 0-7, then row 1 pointer
// R22 - 1:9 second pass: bit 0 into row 8
// R23 - register select 01 data, 00/10 command
// R24 - column and row pointer updated together
`timescale 1ns/1ps
`default_nettype none
`include "lcdm_defs.svh"

module lcdm_top
	import lcdm_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic frame_clk,
	input wire logic hw_address_bit_low,
	input wire logic hw_address_bit_high,
	output logic [8:0] backplane_pin,
	output logic [101:0] segment_pin
);

	// ==========================================
	// input synchronisers
	logic [2:0] frame_sync;
	logic [1:0] hwa_meta;
	logic [1:0] hw_addr;
	logic frame_step;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			frame_sync <= 3'h0;
			hwa_meta <= 2'h0;
			hw_addr <= 2'h0;
		end else begin
			frame_sync <= {frame_sync[1:0], frame_clk};
			hwa_meta <= {hw_address_bit_high, hw_address_bit_low};
			hw_addr <= hwa_meta;
		end
	end

	// only stages 1 and 2 feed the edge detector, never stage 0
	assign frame_step = frame_sync[1] & ~frame_sync[2];

	// ==========================================
	// apb decode
	logic setup_ph;
	logic wr_en;
	logic sel_mode;
	logic sel_ptr;
	logic sel_ctrl;
	logic sel_data;
	logic sel_stat;
	logic mapped;

	assign setup_ph = psel & ~penable;
	assign wr_en = psel & penable & pready & pwrite;
	assign sel_mode = (paddr == `LCDM_OFF_MODE);
	assign sel_ptr = (paddr == `LCDM_OFF_PTR);
	assign sel_ctrl = (paddr == `LCDM_OFF_CTRL);
	assign sel_data = (paddr == `LCDM_OFF_DATA);
	assign sel_stat = (paddr == `LCDM_OFF_STAT);
	assign mapped = sel_mode | sel_ptr | sel_ctrl | sel_data | sel_stat;

	// ==========================================
	// control state
	lcdm_mode_e mode;
	logic [1:0] dev_addr;
	logic [1:0] rs_field;
	logic [6:0] col;
	logic [3:0] row;
	logic stopped;
	logic [8:0][101:0] ram;
	logic [101:0] disp;
	logic [3:0] phase;
	logic step_d;

	logic data_wr;
	logic addr_match;
	logic store_en;
	logic [6:0] next_col;
	logic [3:0] next_row;
	logic next_stop;

	assign data_wr = wr_en & sel_data & (rs_field == `LCDM_RS_RAM); // R23
	assign addr_match = (dev_addr == hw_addr);
	assign store_en = data_wr & addr_match & ~stopped; // R14 R11

	// ==========================================
	// bit placement
	function automatic logic [11:0] place(input lcdm_mode_e m, input logic [6:0] c,
		input logic [3:0] r, input int i);
		int tc;
		int tr;
		int k;
		logic ok;
		tc = 0;
		tr = 0;
		k = int'(r) + i;
		ok = 1'b1;
		case (m)
			LCDM_STATIC: begin
				tr = int'(r);
				tc = int'(c) + i; // R16
			end
			LCDM_MUX2: begin
				tr = int'(r) + (i % 2);
				tc = int'(c) + i / 2; // R17
			end
			LCDM_MUX4: begin
				tr = int'(r) + (i % 4);
				tc = int'(c) + i / 4; // R18
			end
			LCDM_MUX6: begin
				tr = k % 6;
				tc = int'(c) + k / 6; // R19
			end
			LCDM_MUX8: begin
				tr = i;
				tc = int'(c); // R20
			end
			LCDM_MUX9: begin
				tr = (r == 4'h0) ? i : int'(`LCDM_LAST_ROW); // R21 R22
				tc = int'(c);
				ok = (r == 4'h0) || (i == 7);
			end
			default: ok = 1'b0;
		endcase
		ok = ok && (tc <= int'(`LCDM_LAST_COL)) && (tr <= int'(`LCDM_LAST_ROW)); // R11
		return {ok, 4'(tr), 7'(tc)};
	endfunction

	// ==========================================
	// pointer advance
	always_comb begin
		int nc;
		int nr;
		nc = int'(col);
		nr = int'(row);
		case (mode)
			LCDM_STATIC: nc = int'(col) + 8;
			LCDM_MUX2: nc = int'(col) + 4;
			LCDM_MUX4: nc = int'(col) + 2;
			LCDM_MUX6: begin
				nc = int'(col) + (int'(row) + 8) / 6;
				nr = (int'(row) + 8) % 6;
			end
			LCDM_MUX8: nc = int'(col) + 1;
			LCDM_MUX9: begin
				if (row == 4'h0 && col == `LCDM_LAST_COL) begin
					nc = 0; // R21
					nr = 1;
				end else begin
					nc = int'(col) + 1;
				end
			end
			default: nc = int'(col);
		endcase
		// overrun keeps the last position rather than wrapping
		next_stop = (nc > int'(`LCDM_LAST_COL)); // R11 R10
		next_col = next_stop ? col : 7'(nc);
		next_row = next_stop ? row : 4'(nr);
	end

	// ==========================================
	// registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode <= LCDM_STATIC;
			dev_addr <= `LCDM_DEVA_RST;
			rs_field <= `LCDM_RS_RST;
			col <= 7'h0;
			row <= 4'h0;
			stopped <= 1'b0;
		end else begin
			if (wr_en && sel_mode) begin
				mode <= lcdm_mode_e'(pwdata[`LCDM_MODE_MSB:`LCDM_MODE_LSB]);
				dev_addr <= pwdata[`LCDM_DEVA_MSB:`LCDM_DEVA_LSB];
			end
			if (wr_en && sel_ctrl) begin
				rs_field <= pwdata[`LCDM_RS_MSB:`LCDM_RS_LSB];
			end
			if (wr_en && sel_ptr) begin
				col <= pwdata[`LCDM_PCOL_MSB:`LCDM_PCOL_LSB]; // R9
				row <= pwdata[`LCDM_PROW_MSB:`LCDM_PROW_LSB];
				stopped <= 1'b0;
			end else if (data_wr && !stopped) begin
				col <= next_col; // R24 R14
				row <= next_row;
				stopped <= next_stop;
			end
		end
	end

	// ==========================================
	// display ram, written the edge the byte lands
	always_ff @(posedge pclk or negedge presetn) begin
		logic [11:0] t;
		t = 12'h0;
		if (!presetn) begin
			ram <= '0;
		end else if (store_en) begin
			for (int i = 0; i < 8; i++) begin
				t = place(mode, col, row, i);
				if (t[11]) begin
					ram[t[10:7]][t[6:0]] <= pwdata[7 - i]; // R8 R5
				end
			end
		end
	end

	// ==========================================
	// display register and segments
	lcdm_scan u_scan (
		.pclk(pclk),
		.presetn(presetn),
		.mode(mode),
		.step(frame_step),
		.phase(phase),
		.backplane_pin(backplane_pin)
	);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			step_d <= 1'b0;
			disp <= '0;
			segment_pin <= '0;
		end else begin
			step_d <= frame_step;
			if (step_d) begin
				disp <= ram[phase]; // R6 R7
			end
			segment_pin <= disp; // R4
		end
	end

	// ==========================================
	// apb response
	logic [31:0] rd_mux;

	assign rd_mux = sel_mode ? {26'h0, dev_addr, 1'b0, mode} :
		sel_ptr ? {20'h0, row, 1'b0, col} :
		sel_ctrl ? {25'h0, rs_field, 5'h0} :
		sel_stat ? {12'h0, phase, 1'b0, hw_addr, stopped, row, 1'b0, col} : 32'h0;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end else begin
			pready <= setup_ph;
			pslverr <= setup_ph & ~mapped;
			prdata <= (setup_ph && !pwrite) ? rd_mux : 32'h0;
		end
	end

	// ==========================================
	// checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_byte8;
		data_wr && mode == LCDM_MUX8 && !stopped && col < `LCDM_LAST_COL;
	endsequence

	chk_mux8_step_one: assert property (s_byte8 |=> col == $past(col) + 7'h1) // R10
		else $error("1:8 pointer did not step by one");
	chk_mux8_bit7_row0: assert property ( // R20
		(s_byte8 and addr_match) |=> ram[0][$past(col, 1)] == $past(pwdata[7], 1))
		else $error("bit 7 not in row 0");
	chk_mismatch_no_store: assert property (data_wr && !addr_match |=> $stable(ram)) // R14
		else $error("ram written on address mismatch");
	chk_stop_holds: assert property ( // R11
		stopped && !(wr_en && sel_ptr) |=> stopped && $stable(col) && $stable(row))
		else $error("stopped pointer moved");
	chk_mux9_row8_only: assert property ( // R22
		data_wr && mode == LCDM_MUX9 && row != 4'h0 |=> $stable(ram[7:0]))
		else $error("1:9 second pass touched rows 0-7");
	chk_disp_held: assert property (!step_d |=> $stable(disp)) // R7
		else $error("display register changed mid-phase");
	chk_apb_one_wait: assert property (setup_ph |=> pready ##1 !pready)
		else $error("pready timing wrong");

endmodule // lcdm_top

`default_nettype wire

/* File: lcdm_host.sv */
`timescale 1ns/1ps
`default_nettype none

// ==========================================
// apb host model, one transfer at a time
module lcdm_host (
	input wire logic pclk,
	input wire logic pready,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
	end

	// call just after a rising edge; ends after one idle edge
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// no limit of its own: only the bench timeout ends a hung wait
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		// released data flipped so stale values never look valid
		pwdata <= ~d;
		paddr <= ~a;
		@(posedge pclk);
	endtask
endmodule // lcdm_host

`default_nettype wire

/* File: lcdm_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "lcdm_defs.svh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin mismatches++; \
	$display("unexpected at %0t: got %h want %h", $time, a, b); end end

module lcdm_top_tb;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic frame_clk = 1'b0;
	logic frame_run = 1'b0;
	logic hw_address_bit_low = 1'b0;
	logic hw_address_bit_high = 1'b0;
	logic snap = 1'b0;
	logic psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [8:0] backplane_pin;
	logic [101:0] segment_pin;
	logic [32:0] rdq [$];
	logic [110:0] bpq [$];
	logic [32:0] exp_rd;
	logic [110:0] exp_bp;
	int mismatches = 0;
	int tests_run = 0;
	int cycles = 0;
	logic [2:0] tm [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h3, 3'h4, 3'h5};
	logic [3:0] tr [7] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h4, 4'h0, 4'h0};
	logic [6:0] tc [7] = '{7'h08, 7'h04, 7'h02, 7'h01, 7'h02, 7'h01, 7'h01};
	logic [3:0] te [7] = '{4'h0, 4'h0, 4'h0, 4'h2, 4'h0, 4'h0, 4'h0};
	int nph [6] = '{1, 2, 4, 6, 8, 9};
	int rpc [6] = '{1, 2, 4, 6, 8, 8};
	logic [35:0] bpt [6] = '{36'h000000000, 36'h010101010, 36'h012303210,
		36'h012345210, 36'h012345670, 36'h012345678};

	// ==========================================
	// clocks and instances
	always #5 pclk = ~pclk;
	// scan clock parks low between bursts so phase is known
	always #80 if (frame_run || frame_clk) frame_clk = ~frame_clk;

	lcdm_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .frame_clk(frame_clk),
		.hw_address_bit_low(hw_address_bit_low),
		.hw_address_bit_high(hw_address_bit_high),
		.backplane_pin(backplane_pin), .segment_pin(segment_pin));

	lcdm_host host (.pclk(pclk), .pready(pready), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

	// ==========================================
	// tasks
	task automatic close_out();
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		host.xfer(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [32:0] e);
		rdq.push_back(e);
		host.xfer(1'b0, a, 32'h0);
	endtask

	function automatic logic [31:0] stat(input logic [6:0] c, input logic [3:0] r, input logic s);
		return {19'h0, s, r, 1'b0, c};
	endfunction

	task automatic do_reset();
		presetn <= 1'b0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
	endtask

	task automatic frames(input int k);
		frame_run = 1'b1;
		repeat (k) @(posedge frame_clk);
		frame_run = 1'b0;
		repeat (10) @(posedge pclk);
	endtask

	// ==========================================
	// monitor
	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			mismatches++;
			close_out();
		end
		if (psel && penable && pready && !pwrite) begin
			exp_rd = rdq.pop_front();
			`CHK({pslverr, prdata}, exp_rd)
		end
		if (snap) begin
			// pop once: the macro names its arguments twice
			exp_bp = bpq.pop_front();
			`CHK({backplane_pin, segment_pin}, exp_bp)
		end
	end

	// ==========================================
	// main sequence
	initial begin
		logic [7:0] b;
		logic [101:0] sx;
		logic [8:0] bp;
		int k, p, m;
		b = 8'($urandom(32'h2e92));
		do_reset();
		rd(8'h14, {1'b1, 32'h0});
		rd(`LCDM_OFF_STAT, {1'b0, stat(7'h00, 4'h0, 1'b0)});
		// one step per mode; commands in ctrl must not move the pointer
		for (int i = 0; i < 7; i++) begin
			wr(`LCDM_OFF_MODE, {29'h0, tm[i]});
			wr(`LCDM_OFF_PTR, {20'h0, tr[i], 8'h00});
			for (int j = 0; j < 3; j++) begin
				wr(`LCDM_OFF_CTRL, {25'h0, j[1:0], 5'h00});
				wr(`LCDM_OFF_DATA, $urandom);
			end
			rd(`LCDM_OFF_STAT, {1'b0, stat(tc[i], te[i], 1'b0)});
		end
		wr(`LCDM_OFF_CTRL, 32'h20);
		wr(`LCDM_OFF_MODE, 32'h5);
		wr(`LCDM_OFF_PTR, 32'h65);
		wr(`LCDM_OFF_DATA, $urandom);
		rd(`LCDM_OFF_STAT, {1'b0, stat(7'h00, 4'h1, 1'b0)});
		wr(`LCDM_OFF_PTR, 32'h165);
		repeat (2) wr(`LCDM_OFF_DATA, 32'hff);
		rd(`LCDM_OFF_STAT, {1'b0, stat(7'h65, 4'h1, 1'b1)});
		wr(`LCDM_OFF_PTR, 32'h100);
		rd(`LCDM_OFF_STAT, {1'b0, stat(7'h00, 4'h1, 1'b0)});
		wr(`LCDM_OFF_MODE, 32'h0);
		wr(`LCDM_OFF_PTR, 32'h0);
		repeat (14) wr(`LCDM_OFF_DATA, $urandom);
		rd(`LCDM_OFF_STAT, {1'b0, stat(7'h60, 4'h0, 1'b1)});
		// fresh reset per mode so the scan phase is known
		for (m = 0; m < 6; m++) begin
			hw_address_bit_low <= 1'b0;
			do_reset();
			wr(`LCDM_OFF_MODE, {26'h0, 2'h1, 1'b0, 3'(m)});
			wr(`LCDM_OFF_CTRL, 32'h20);
			wr(`LCDM_OFF_PTR, 32'h10);
			wr(`LCDM_OFF_DATA, 32'hff);
			if (m >= 4)
				rd(`LCDM_OFF_STAT, {1'b0, stat(7'h11, 4'h0, 1'b0)});
			hw_address_bit_low <= 1'b1;
			repeat (4) @(posedge pclk);
			wr(`LCDM_OFF_PTR, 32'h0);
			b = 8'($urandom);
			wr(`LCDM_OFF_DATA, {24'h0, b});
			k = $urandom_range(12, 1);
			frames(k);
			p = k % nph[m];
			sx = '0;
			for (int i = 0; i < 8; i++) begin
				if (i % rpc[m] == p)
					sx[i / rpc[m]] = b[7 - i];
			end
			for (int n = 0; n < 9; n++)
				bp[n] = (bpt[m][35 - 4 * n -: 4] == p);
			bpq.push_back({bp, sx});
			snap <= 1'b1;
			@(posedge pclk);
			snap <= 1'b0;
		end
		repeat (2) @(posedge pclk);
		close_out();
	end
endmodule // lcdm_top_tb

`default_nettype wire
